// >>> dcc_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants for the channel control block
// ****************************************************************
package dcc_pkg;

  localparam int           NCH         = 3;      // Channels behind the vector
  localparam logic [3:0]   NCH_NIB     = 4'h3;   // Channel count at address width
  // Register map: channel c sits at c*16, vector register after them
  localparam logic [1:0]   REG_CTL     = 2'h0;
  localparam logic [1:0]   REG_SA      = 2'h1;
  localparam logic [1:0]   REG_DA      = 2'h2;
  localparam logic [1:0]   REG_SZ      = 2'h3;
  localparam logic [7:0]   ADDR_IV     = 8'h30;
  // Control field positions
  localparam int           CTL_START   = 0;
  localparam int           CTL_ABORT   = 1;
  localparam int           CTL_IE      = 2;
  localparam int           CTL_FLAG    = 3;
  localparam int           CTL_EN      = 4;
  localparam int           CTL_LEVEL   = 5;
  localparam int           CTL_SUNIT   = 6;
  localparam int           CTL_DUNIT   = 7;
  localparam int           CTL_SSTEP   = 8;
  localparam int           CTL_DSTEP   = 10;
  localparam int           CTL_MODE    = 12;
  localparam int           MODE_REP    = 14;     // Repeat bit of the mode field
  localparam logic [15:0]  CTL_WMASK   = 16'hfffe; // Start bit is never stored
  // Stepping codes and amounts
  localparam logic [1:0]   STEP_DEC    = 2'h2;
  localparam logic [1:0]   STEP_INC    = 2'h3;
  localparam logic [1:0]   STEP_BYTE   = 2'h1;
  localparam logic [1:0]   STEP_WORD   = 2'h2;
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } dcc_state_e;

  typedef struct packed {
    dcc_state_e               state;   // Engine state
    logic [1:0]               cur;     // Channel being served
    logic [NCH-1:0][15:0]     ctl;     // Channel control
    logic [NCH-1:0][19:0]     sa;      // Programmed source
    logic [NCH-1:0][19:0]     da;      // Programmed destination
    logic [NCH-1:0][15:0]     sz;      // Programmed block size
    logic [NCH-1:0][19:0]     wsa;     // Working source copy
    logic [NCH-1:0][19:0]     wda;     // Working destination copy
    logic [NCH-1:0][15:0]     cnt;     // Working size count
    logic [NCH-1:0]           pend;    // Trigger waiting
    logic [NCH-1:0]           blk;     // Block under way
    logic [NCH-1:0]           filt;    // Filtered trigger level
    logic [NCH-1:0][2:0]      tsync;   // Trigger synchronisers, [0] first
    logic [2:0]               nsync;   // Abort input synchroniser
    logic                     nfilt;   // Filtered abort level
    logic                     aw_ok;
    logic                     w_ok;
    logic [7:0]               awaddr;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
  } dcc_state_s;

  localparam dcc_state_s DCC_RST = '{state: ST_IDLE, default: '0};

  // Address decode: {hit, channel, register}
  function automatic logic [4:0] dcc_decode(input logic [7:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0) && (a[7:4] < NCH_NIB);
    return {hit, a[5:4], a[3:2]};
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] dcc_bmerge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = din[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// >>> dcc_dma_channel_control_regs.sv
// Summary of operation
// - Source step: 00/01 hold, 10 down, 11 up
// - Control bit 7: destination byte, else word
// - Control bit 6: source byte, else word
// - Control bit 5: level trigger, else rising edge
// - Control bit 4 enables; cleared means no transfers
// - Control bit 3 is the pending flag
// - Control bit 2 gates pending onto interrupt
// - Control bit 1 set when abort cuts sequence
// - Control bit 0 starts transfer, self-clears
// - Source register: 20 bits, upper read zero
// - Source register untouched; working copy steps
// - Destination register: 20 bits, upper read zero
// - Destination register untouched; working copy steps
// - Narrow write clears address bits 19 to 16
// - Size count falls per unit moved
// - Count at zero reloads programmed size
// - Size zero disables transfers
// - Vector returns 0/2/4/6, channel 0 first
// - Mode field: single, block, burst, repeated forms
// - Step is one for bytes, two for words
`timescale 1ns/1ps
`default_nettype none
module dcc_dma_channel_control_regs
  import dcc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [NCH-1:0]    trig_in,
  input  wire logic              nmi_in,
  output logic                   mem_req,
  output logic [1:0]             mem_chan,
  output logic [19:0]            mem_src_addr,
  output logic [19:0]            mem_dst_addr,
  output logic                   mem_src_byte,
  output logic                   mem_dst_byte,
  input  wire logic              mem_ack,
  output logic                   irq
);

  // ****************************************************************
  // State and helper terms
  // ****************************************************************
  dcc_state_s         st_ff;       // All state of the block
  dcc_state_s         nxt_st;      // Its next value
  logic               aw_fire;     // Write address taken
  logic               w_fire;      // Write data taken
  logic               ar_fire;     // Read address taken
  logic               wr_fire;     // Both halves held, write applied
  logic [4:0]         wr_dec;      // Decoded write address
  logic [4:0]         rd_dec;      // Decoded read address
  logic               rd_iv;       // Read of the vector register
  logic               busy_ack;    // Current unit finished
  logic               nmi_rise;    // Filtered abort edge
  logic [NCH-1:0]     trig_rise;   // Filtered trigger edges
  logic [NCH-1:0]     want;        // Channel ready to move a unit
  logic [31:0]        m32;         // Merged write word
  logic [1:0]         wc;          // Written channel
  logic               ivf;         // Any flag pending
  logic [1:0]         ivc;         // Highest-priority pending channel
  logic               go;          // Arbitration found a channel
  logic [1:0]         gc;          // Winning channel
  logic [1:0]         ac;          // Channel being acknowledged
  logic [1:0]         sstep;       // Source step amount
  logic [1:0]         dstep;       // Destination step amount
  logic [15:0]        cur_ctl;     // Control of the served channel
  logic [19:0]        cur_wsa;     // Working source of served channel
  logic [19:0]        cur_wda;     // Working destination of served channel
  logic [15:0]        cur_cnt;     // Count of served channel
  logic [NCH-1:0]     pset;        // Request raised this cycle; beats the clear at the unit's ack

  assign aw_fire  = awvalid && awready;
  assign w_fire   = wvalid && wready;
  assign ar_fire  = arvalid && arready;
  assign wr_fire  = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
  assign wr_dec   = dcc_decode(st_ff.awaddr);
  assign rd_dec   = dcc_decode(araddr);
  assign rd_iv    = (araddr == ADDR_IV);
  assign busy_ack = (st_ff.state == ST_BUSY) && mem_ack;
  assign nmi_rise = (st_ff.nsync[1] == st_ff.nsync[2]) && st_ff.nsync[2] && !st_ff.nfilt;
  assign cur_ctl  = st_ff.ctl[st_ff.cur];
  assign cur_wsa  = st_ff.wsa[st_ff.cur];
  assign cur_wda  = st_ff.wda[st_ff.cur];
  assign cur_cnt  = st_ff.cnt[st_ff.cur];

  // Per-channel trigger edge and readiness
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    // Edge counts only once the second and third stages agree
    assign trig_rise[c] = (st_ff.tsync[c][1] == st_ff.tsync[c][2])
                          && st_ff.tsync[c][2] && !st_ff.filt[c];
    // Zero size or cleared enable keeps the channel quiet
    assign want[c] = st_ff.ctl[c][CTL_EN] && (st_ff.sz[c] != 16'h0)
                     && (st_ff.pend[c] || st_ff.blk[c]
                         || (st_ff.ctl[c][CTL_LEVEL] && st_ff.filt[c]));
  end

  // ****************************************************************
  // Bus handshakes and transfer port
  // ****************************************************************
  // One write and one read in flight; halves stall until answered
  assign awready      = !st_ff.aw_ok && !st_ff.bvalid;
  assign wready       = !st_ff.w_ok && !st_ff.bvalid;
  assign arready      = !st_ff.rvalid;
  assign bvalid       = st_ff.bvalid;
  assign bresp        = st_ff.bresp;
  assign rvalid       = st_ff.rvalid;
  assign rresp        = st_ff.rresp;
  assign rdata        = st_ff.rdata;
  assign mem_req      = (st_ff.state == ST_BUSY);
  assign mem_chan     = st_ff.cur;
  assign mem_src_addr = cur_wsa;
  assign mem_dst_addr = cur_wda;
  assign mem_src_byte = cur_ctl[CTL_SUNIT];
  assign mem_dst_byte = cur_ctl[CTL_DUNIT];

  // Any channel with flag and interrupt enable (bit 2) raises the shared line
  always_comb begin
    irq = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      irq = irq | (st_ff.ctl[c][CTL_FLAG] & st_ff.ctl[c][CTL_IE]);
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Order matters: software first, then hardware, so hardware wins
  always_comb begin
    nxt_st = st_ff;
    m32    = 32'h0;
    wc     = 2'h0;
    ivf    = 1'b0;
    ivc    = 2'h0;
    go     = 1'b0;
    gc     = 2'h0;
    ac     = st_ff.cur;
    pset   = '0;
    sstep  = st_ff.ctl[ac][CTL_SUNIT] ? STEP_BYTE : STEP_WORD;
    dstep  = st_ff.ctl[ac][CTL_DUNIT] ? STEP_BYTE : STEP_WORD;
    // Three-stage synchronisers and agreement filters
    for (int c = 0; c < NCH; c++) begin
      nxt_st.tsync[c] = {st_ff.tsync[c][1:0], trig_in[c]};
      if (st_ff.tsync[c][1] == st_ff.tsync[c][2]) begin
        nxt_st.filt[c] = st_ff.tsync[c][2];
      end
    end
    nxt_st.nsync = {st_ff.nsync[1:0], nmi_in};
    if (st_ff.nsync[1] == st_ff.nsync[2]) begin
      nxt_st.nfilt = st_ff.nsync[2];
    end
    // Capture write halves in either order
    if (aw_fire) begin
      nxt_st.aw_ok  = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (w_fire) begin
      nxt_st.w_ok  = 1'b1;
      nxt_st.wdata = wdata;
      nxt_st.wstrb = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // Apply a complete write
    if (wr_fire) begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      // The read-only vector accepts writes silently
      nxt_st.bresp  = (wr_dec[4] || st_ff.awaddr == ADDR_IV) ? RESP_OKAY : RESP_SLVERR;
      wc            = wr_dec[3:2];
      if (wr_dec[4]) begin
        case (wr_dec[1:0])
          REG_CTL: begin
            m32 = dcc_bmerge({16'h0, st_ff.ctl[wc]}, st_ff.wdata, st_ff.wstrb);
            // Enabling loads fresh working copies
            if (m32[CTL_EN] && !st_ff.ctl[wc][CTL_EN]) begin
              nxt_st.cnt[wc] = st_ff.sz[wc];
              nxt_st.wsa[wc] = st_ff.sa[wc];
              nxt_st.wda[wc] = st_ff.da[wc];
              nxt_st.blk[wc] = 1'b0;
            end
            // Start is a strobe: recorded as pending, never stored
            if (m32[CTL_START]) begin
              nxt_st.pend[wc] = 1'b1;
              pset[wc]        = 1'b1;
            end
            nxt_st.ctl[wc] = m32[15:0] & CTL_WMASK;
          end
          REG_SA: begin
            m32 = dcc_bmerge({12'h0, st_ff.sa[wc]}, st_ff.wdata, st_ff.wstrb);
            if (!st_ff.wstrb[2] && (st_ff.wstrb[1:0] != 2'h0)) begin
              m32[19:16] = 4'h0;
            end
            nxt_st.sa[wc] = m32[19:0];
          end
          REG_DA: begin
            m32 = dcc_bmerge({12'h0, st_ff.da[wc]}, st_ff.wdata, st_ff.wstrb);
            if (!st_ff.wstrb[2] && (st_ff.wstrb[1:0] != 2'h0)) begin
              m32[19:16] = 4'h0;
            end
            nxt_st.da[wc] = m32[19:0];
          end
          default: begin
            m32 = dcc_bmerge({16'h0, st_ff.sz[wc]}, st_ff.wdata, st_ff.wstrb);
            nxt_st.sz[wc] = m32[15:0];
            // A block in progress keeps its count until it ends
            if (!st_ff.blk[wc] && !(mem_req && st_ff.cur == wc)) begin
              nxt_st.cnt[wc] = m32[15:0];
            end
          end
        endcase
      end
    end
    // Rising trigger edges queue one request in edge mode
    for (int c = 0; c < NCH; c++) begin
      if (trig_rise[c] && !st_ff.ctl[c][CTL_LEVEL]) begin
        nxt_st.pend[c] = 1'b1;
        pset[c]        = 1'b1;
      end
    end
    // Reads answer one cycle after the address is taken
    for (int c = NCH - 1; c >= 0; c--) begin
      if (st_ff.ctl[c][CTL_FLAG]) begin
        ivf = 1'b1;
        ivc = 2'(c);
      end
    end
    if (ar_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = 32'h0;
      if (rd_iv) begin
        // Lowest channel wins; its flag is consumed by the read
        if (ivf) begin
          nxt_st.rdata = {28'h0, ({1'b0, ivc} + 3'h1), 1'b0};
          nxt_st.ctl[ivc][CTL_FLAG] = 1'b0;
        end
      end else if (rd_dec[4]) begin
        case (rd_dec[1:0])
          REG_CTL: nxt_st.rdata = {16'h0, st_ff.ctl[rd_dec[3:2]]};
          REG_SA:  nxt_st.rdata = {12'h0, st_ff.sa[rd_dec[3:2]]};
          REG_DA:  nxt_st.rdata = {12'h0, st_ff.da[rd_dec[3:2]]};
          default: nxt_st.rdata = {16'h0, st_ff.sz[rd_dec[3:2]]};
        endcase
      end else begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end
    // Transfer engine: fixed priority, one unit per grant
    case (st_ff.state)
      ST_IDLE: begin
        for (int c = NCH - 1; c >= 0; c--) begin
          if (want[c]) begin
            go = 1'b1;
            gc = 2'(c);
          end
        end
        if (go) begin
          nxt_st.state = ST_BUSY;
          nxt_st.cur   = gc;
        end
      end
      ST_BUSY: begin
        if (mem_ack) begin
          nxt_st.state    = ST_IDLE;
          // A start or edge landing with the ack stays queued
          nxt_st.pend[ac] = pset[ac];
          // Only working copies step; programmed addresses stay
          case (st_ff.ctl[ac][CTL_SSTEP +: 2])
            STEP_DEC: nxt_st.wsa[ac] = st_ff.wsa[ac] - {18'h0, sstep};
            STEP_INC: nxt_st.wsa[ac] = st_ff.wsa[ac] + {18'h0, sstep};
            default:  nxt_st.wsa[ac] = st_ff.wsa[ac];
          endcase
          case (st_ff.ctl[ac][CTL_DSTEP +: 2])
            STEP_DEC: nxt_st.wda[ac] = st_ff.wda[ac] - {18'h0, dstep};
            STEP_INC: nxt_st.wda[ac] = st_ff.wda[ac] + {18'h0, dstep};
            default:  nxt_st.wda[ac] = st_ff.wda[ac];
          endcase
          if (st_ff.cnt[ac] == 16'h1) begin
            // Last unit: reload everything, flag, stop unless repeated
            nxt_st.cnt[ac]           = st_ff.sz[ac];
            nxt_st.wsa[ac]           = st_ff.sa[ac];
            nxt_st.wda[ac]           = st_ff.da[ac];
            nxt_st.blk[ac]           = 1'b0;
            nxt_st.ctl[ac][CTL_FLAG] = 1'b1;
            if (!st_ff.ctl[ac][MODE_REP]) begin
              nxt_st.ctl[ac][CTL_EN] = 1'b0;
            end
          end else begin
            nxt_st.cnt[ac] = st_ff.cnt[ac] - 16'h1;
            // Block and burst modes carry on without a new trigger
            nxt_st.blk[ac] = (st_ff.ctl[ac][CTL_MODE +: 2] != 2'h0);
          end
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase
    // Abort: the unit on the bus finishes, later units do not start
    if (nmi_rise) begin
      for (int c = 0; c < NCH; c++) begin
        if (st_ff.ctl[c][CTL_EN] && (st_ff.blk[c] || (mem_req && st_ff.cur == 2'(c)))) begin
          nxt_st.ctl[c][CTL_ABORT] = 1'b1;
          nxt_st.ctl[c][CTL_EN]    = 1'b0;
          nxt_st.blk[c]            = 1'b0;
          nxt_st.pend[c]           = 1'b0;
        end
      end
    end
  end

  // Register all state; synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= DCC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Assertions and coverage
  // ****************************************************************
  default clocking dcc_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sa_hold_a: assert property (busy_ack && !wr_fire |=> $stable(st_ff.sa))
    else $error("source register changed by a transfer");
  da_hold_a: assert property (busy_ack && !wr_fire |=> $stable(st_ff.da))
    else $error("destination register changed by a transfer");
  src_step_a: assert property (busy_ack && cur_ctl[9:8] == 2'h3 && !cur_ctl[6]
      && cur_cnt != 16'h1 |=> cur_wsa == $past(cur_wsa) + 20'h2)
    else $error("source word increment wrong");
  dst_step_a: assert property (busy_ack && cur_ctl[11:10] == 2'h2 && cur_ctl[7]
      && cur_cnt != 16'h1 |=> cur_wda == $past(cur_wda) - 20'h1)
    else $error("destination byte decrement wrong");
  count_reload_a: assert property (busy_ack && cur_cnt == 16'h1 && !wr_fire
      |=> cur_cnt == st_ff.sz[st_ff.cur] && st_ff.ctl[st_ff.cur][3])
    else $error("count not reloaded at block end");
  zero_size_a: assert property (st_ff.state == ST_IDLE && st_ff.sz[1] == 16'h0
      |=> !(mem_req && mem_chan == 2'h1))
    else $error("zero size channel transferred");
  enable_gate_a: assert property (st_ff.state == ST_IDLE && !st_ff.ctl[1][4]
      |=> !(mem_req && mem_chan == 2'h1))
    else $error("disabled channel started a transfer");
  irq_raise_a: assert property (busy_ack && cur_cnt == 16'h1 && cur_ctl[2]
      && !wr_fire |=> irq)
    else $error("no interrupt after enabled block end");
  iv_code_a: assert property (ar_fire && rd_iv && st_ff.ctl[0][3]
      |=> st_ff.rvalid && st_ff.rdata == 32'h2)
    else $error("vector code for channel zero wrong");
  iv_clear_a: assert property (ar_fire && rd_iv && st_ff.ctl[0][3] && !wr_fire
      && !(busy_ack && st_ff.cur == 2'h0) |=> !st_ff.ctl[0][3])
    else $error("vector read left flag set");
  abort_flag_a: assert property (nmi_rise && st_ff.ctl[1][4] && (st_ff.blk[1]
      || (mem_req && mem_chan == 2'h1)) |=> st_ff.ctl[1][1] && !st_ff.ctl[1][4])
    else $error("abort did not stop the block");
  start_clear_a: assert property (wr_fire && wr_dec == 5'h10 && st_ff.wstrb[0]
      && st_ff.wdata[0] |=> !st_ff.ctl[0][0] && (st_ff.pend[0] || mem_req))
    else $error("start bit not cleared or not queued");
  narrow_clear_a: assert property (wr_fire && wr_dec == 5'h11 && st_ff.wstrb == 4'h3
      |=> st_ff.sa[0][19:16] == 4'h0)
    else $error("narrow write kept upper address bits");

  block_done_c: cover property (busy_ack && cur_cnt == 16'h1 && cur_ctl[13:12] != 2'h0);
  abort_hit_c:  cover property (nmi_rise && mem_req);
  iv_read_c:    cover property (ar_fire && rd_iv && ivf && ivc == 2'h2);
  level_run_c:  cover property (mem_req && cur_ctl[5] && cur_ctl[14]);

endmodule // dcc_dma_channel_control_regs
`default_nettype wire

// >>> dcc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_mem_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        mem_req,
  input  wire logic [19:0] mem_src_addr,
  input  wire logic [19:0] mem_dst_addr,
  input  wire logic [1:0]  mem_chan,
  input  wire logic        mem_src_byte,
  input  wire logic        mem_dst_byte,
  output logic [3:0]       last_info,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic [7:0]       units,
  output logic [19:0]      last_src,
  output logic [19:0]      last_dst
);
  logic [2:0] wait_ff;  // Cycles the offered unit has waited
  // ************************************************
  // Memory side: one ack pulse per offered unit
  // ************************************************
  // Slow mode stalls each unit to let the abort land mid-block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack  <= 1'b0;
      wait_ff  <= 3'h0;
      units    <= 8'h00;
      last_src <= 20'h00000;
      last_dst <= 20'h00000;
      last_info <= 4'h0;
    end else if (mem_ack) begin
      // Unit ends here; keep its addresses
      mem_ack  <= 1'b0;
      wait_ff  <= 3'h0;
      units    <= units + 8'h01;
      last_src <= mem_src_addr;
      last_dst <= mem_dst_addr;
      last_info <= {mem_chan, mem_src_byte, mem_dst_byte};
    end else if (mem_req) begin
      wait_ff <= wait_ff + 3'h1;
      mem_ack <= (wait_ff >= (slow ? 3'h4 : 3'h0));
    end
  end
endmodule  // dcc_mem_model
`default_nettype wire

// >>> dcc_dma_channel_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_dma_channel_control_regs_tb import dcc_pkg::*;;
  logic           aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic           awready, wready, bvalid, arready, rvalid, nmi_in, slow;
  logic           mem_req, mem_ack, irq;
  logic [7:0]     awaddr, araddr, units, u0;
  logic [31:0]    wdata, rdata, rd;
  logic [3:0]     wstrb;
  logic [1:0]     bresp, rresp, rs;
  logic [NCH-1:0] trig_in;
  logic [19:0]    src_a, dst_a, last_src, last_dst;
  logic [1:0]     chan;
  logic           sb, db;
  logic [3:0]     last_info;
  int             miscompares, samples_checked;
  dcc_dma_channel_control_regs u_dcc_dma_channel_control_regs (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .trig_in, .nmi_in,
    .mem_req, .mem_chan(chan), .mem_src_addr(src_a), .mem_dst_addr(dst_a),
    .mem_src_byte(sb), .mem_dst_byte(db), .mem_ack, .irq);
  dcc_mem_model u_dcc_mem_model (.aclk, .aresetn, .mem_req, .mem_src_addr(src_a),
    .mem_dst_addr(dst_a), .mem_chan(chan), .mem_src_byte(sb), .mem_dst_byte(db),
    .last_info, .slow, .mem_ack, .units, .last_src, .last_dst);
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A used-up wait counts as a miss and ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad;
    logic wd;
    int   n;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (bvalid) break;
      if (awready && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready && !wd) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    bready <= 1'b0;
    rs = bresp;
    bound(n, 64);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    bound(n, 64);
  endtask
  // Waits on the memory model's unit count, bounded
  task automatic wait_units(input logic [7:0] u);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (units === u) break;
    end
    bound(n, 400);
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, nmi_in, slow} = '0;
    {awaddr, araddr, wdata, wstrb, trig_in} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h00); chk(rd, 32'h0);
    rdr(8'h40); chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'h04, 32'hffffffff, 4'hf); rdr(8'h04); chk(rd, 32'h000fffff);
    wr(8'h04, 32'h00000100, 4'h3); rdr(8'h04); chk(rd, 32'h100);
    wr(8'h08, 32'hfff00200, 4'hf); rdr(8'h08); chk(rd, 32'h200);
    $display("test registers done");
    // Ch0 block of two: source up by words, destination down by bytes
    wr(8'h0c, 32'h2, 4'hf);
    wr(8'h00, 32'h1b95, 4'hf);
    wait_units(8'h02);
    chk({12'h0, last_src}, 32'h102);
    chk({12'h0, last_dst}, 32'h1ff);
    chk({28'h0, last_info}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdr(8'h00); chk(rd, 32'h1b8c);
    rdr(8'h04); chk(rd, 32'h100);
    rdr(8'h08); chk(rd, 32'h200);
    rdr(8'h0c); chk(rd, 32'h2);
    rdr(ADDR_IV); chk(rd, 32'h2);
    chk({31'h0, irq}, 32'h0);
    rdr(ADDR_IV); chk(rd, 32'h0);
    $display("test block done");
    // Ch2 single unit on a rising trigger, interrupt left disabled
    wr(8'h2c, 32'h1, 4'hf);
    wr(8'h20, 32'h0050, 4'hf);
    trig_in <= 3'b100;
    wait_units(8'h03);
    chk({31'h0, irq}, 32'h0);
    chk({28'h0, last_info}, 32'ha);
    rdr(ADDR_IV); chk(rd, 32'h6);
    trig_in <= 3'b000;
    // Ch2 repeated single on a high level runs past its block end
    wr(8'h2c, 32'h2, 4'hf);
    wr(8'h20, 32'h4030, 4'hf);
    trig_in <= 3'b100;
    wait_units(8'h06);
    trig_in <= 3'b000;
    repeat (12) @(posedge aclk);
    rdr(8'h20); chk(rd & 32'h18, 32'h18);
    $display("test trigger done");
    // Ch1 long block stalled by memory, then aborted
    u0 = units;
    slow <= 1'b1;
    wr(8'h1c, 32'h8, 4'hf);
    wr(8'h10, 32'h1011, 4'hf);
    nmi_in <= 1'b1;
    repeat (20) @(posedge aclk);
    nmi_in <= 1'b0;
    repeat (60) @(posedge aclk);
    rdr(8'h10); chk(rd & 32'h12, 32'h2);
    chk({31'h0, units < u0 + 8'd8}, 32'h1);
    // Zero size keeps the channel quiet
    u0 = units;
    wr(8'h1c, 32'h0, 4'hf);
    wr(8'h10, 32'h0011, 4'hf);
    repeat (30) @(posedge aclk);
    chk({24'h0, units}, {24'h0, u0});
    $display("test abort done");
    report_and_stop();
  end
endmodule  // dcc_dma_channel_control_regs_tb
`default_nettype wire
